// File: dv/wdte_host_model.sv
// Host chipset model: counts wake and SMI assertions.
// Assumes active-low level outputs from the block, same clock.
`timescale 1ns/1ps
module wdte_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Event inputs
	input wire logic wake_output_n,
	input wire logic smi_output_n,
	// Counts
	output int n_wake,
	output int n_smi
);
	logic wake_q;
	logic smi_q;
	// Count falling edges, as an edge-triggered host would latch them
	always @(posedge clk) begin
		wake_q <= wake_output_n;
		smi_q <= smi_output_n;
		if (rst) begin
			n_wake <= 0;
			n_smi <= 0;
		end else begin
			if (wake_q && !wake_output_n) n_wake <= n_wake + 1;
			if (smi_q && !smi_output_n) n_smi <= n_smi + 1;
		end
	end
endmodule // wdte_host_model

// File: dv/wdte_watchdog_test.sv
// Self-checking testbench for the watchdog event block.
// Assumes design files and the host model are compiled first.
`timescale 1ns/1ps
module wdte_watchdog_test;
	logic clk, rst, reg_wr, reg_rd, tick_in;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic wake_n, smi_n, pin, pin_oe, sq_lvl;
	logic [3:0] sq_slot;
	int n_wake, n_smi, n_fail, comparisons, cycles;

	wdte_watchdog #(.TICKS_PER_SECOND(1)) u_dut (.clk(clk), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick_in(tick_in),
		.wake_output_n(wake_n), .smi_output_n(smi_n),
		.shared_watchdog_pin(pin), .shared_watchdog_pin_oe(pin_oe),
		.serirq_slot(sq_slot), .serirq_level(sq_lvl));
	wdte_host_model u_host (.clk(clk), .rst(rst), .wake_output_n(wake_n),
		.smi_output_n(smi_n), .n_wake(n_wake), .n_smi(n_smi));

	// ==================================================
	// Clock, timeout, shared tasks
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			summarize();
		end
	end
	task summarize();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	// Tick pulses, then room for status and outputs to settle
	task ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick_in <= 1'b1;
			@(posedge clk);
			tick_in <= 1'b0;
		end
		repeat (5) @(posedge clk);
	endtask

	// ==================================================
	// Scenarios
	task t_reset();
		rd(8'h12, 8'h00);
		rd(8'h14, 8'h00);
		rd(8'h7F, 8'h00);
		chk({4'h0, wake_n, smi_n, pin_oe, pin}, 8'h0C);
	endtask
	task t_seconds();
		wr(8'h01, 8'h01);
		wr(8'h06, 8'h80);
		wr(8'h44, 8'h10);
		wr(8'h19, 8'h01);
		wr(8'h46, 8'h08);
		wr(8'h13, 8'h50);
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h03);
		rd(8'h12, 8'h03);
		ticks(2);
		rd(8'h14, 8'h00);
		ticks(1);
		rd(8'h14, 8'h01);
		rd(8'h12, 8'h00);
		chk({4'h0, wake_n, smi_n, pin_oe, pin}, 8'h03);
		chk({3'h0, sq_lvl, sq_slot}, 8'h15);
		rd(8'h03, 8'h80);
		rd(8'h18, 8'h01);
		chk(8'(n_wake), 8'h01);
	endtask
	task t_edge();
		wr(8'h03, 8'h80);
		wr(8'h18, 8'h01);
		ticks(0);
		chk({6'h00, wake_n, smi_n}, 8'h03);
		wr(8'h14, 8'h00);
		rd(8'h14, 8'h00);
		wr(8'h14, 8'h01);
		ticks(0);
		chk({6'h00, wake_n, smi_n}, 8'h00);
		chk(8'(n_smi), 8'h02);
		wr(8'h34, 8'h02);
		ticks(0);
		chk({7'h00, pin}, 8'h00);
		wr(8'h34, 8'h00);
		ticks(0);
		chk({7'h00, pin}, 8'h01);
	endtask
	task t_force();
		wr(8'h14, 8'h00);
		wr(8'h12, 8'hC8);
		rd(8'h12, 8'hC8);
		wr(8'h14, 8'h04);
		rd(8'h14, 8'h01);
		ticks(2);
		rd(8'h12, 8'h00);
		wr(8'h14, 8'h00);
		wr(8'h12, 8'h05);
		ticks(1);
		wr(8'h12, 8'h00);
		ticks(6);
		rd(8'h14, 8'h00);
	endtask
	task t_minutes();
		wr(8'h11, 8'h80);
		wr(8'h12, 8'h01);
		ticks(30);
		wr(8'h12, 8'h01);
		ticks(59);
		rd(8'h14, 8'h00);
		ticks(1);
		rd(8'h14, 8'h01);
	endtask

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		tick_in = 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_seconds();
		t_edge();
		t_force();
		t_minutes();
		summarize();
	end
endmodule // wdte_watchdog_test

// File: hdl/wdte_params.svh
// Constants for the watchdog timer event block.
// Assumes inclusion by the package and the design module only.
`ifndef WDTE_PARAMS_SVH
`define WDTE_PARAMS_SVH

// ==================================================
// Register offsets
`define WDTE_OFF_WAKE_GLOBAL_ENABLE 8'h01
`define WDTE_OFF_WAKE_STATUS_TWO 8'h03
`define WDTE_OFF_WAKE_ENABLE_TWO 8'h06
`define WDTE_OFF_TIMEOUT_UNITS 8'h11
`define WDTE_OFF_WATCHDOG_CONFIG 8'h13
`define WDTE_OFF_SMI_STATUS_THREE 8'h18
`define WDTE_OFF_SMI_ENABLE_THREE 8'h19
`define WDTE_OFF_COUNTDOWN_VALUE 8'h12
`define WDTE_OFF_WATCHDOG_CONTROL 8'h14
`define WDTE_OFF_PIN_POLARITY 8'h34
`define WDTE_OFF_SMI_PIN_FUNC 8'h44
`define WDTE_OFF_DOG_PIN_FUNC 8'h46

// ==================================================
// Field positions
`define WDTE_BIT_UNITS_MINUTES 7
`define WDTE_BIT_WAKE_GLOBAL 0
`define WDTE_BIT_WAKE_DOG 7
`define WDTE_BIT_SMI_DOG 0
`define WDTE_BIT_CTRL_STATUS 0
`define WDTE_BIT_CTRL_FORCE 2
`define WDTE_BIT_PIN_POLARITY 1
`define WDTE_SMI_FUNC_HI 5
`define WDTE_SMI_FUNC_LO 4
`define WDTE_DOG_FUNC_HI 3
`define WDTE_DOG_FUNC_LO 2
`define WDTE_MAP_HI 7
`define WDTE_MAP_LO 4

// ==================================================
// Encodings and reset values
`define WDTE_FUNC_SMI 2'h1
`define WDTE_FUNC_DOG 2'h2
`define WDTE_MAP_NONE 4'h0
`define WDTE_REG_RESET 8'h00
`define WDTE_COUNT_ZERO 8'h00
`define WDTE_SECONDS_PER_MINUTE 6'h3C

`endif

// File: hdl/wdte_pkg.sv
// Types shared by the watchdog timer event block.
// Assumes the parameter header is available on the include path.
`include "wdte_params.svh"
package wdte_pkg;
	typedef enum logic [0:0] {WDTE_IDLE, WDTE_RUN} wdte_state_t;
endpackage

// File: hdl/wdte_watchdog.sv
// Watchdog timer with wake, SMI, pin and serial interrupt event routing.
// Assumes a one-cycle strobe per slow tick on tick_in, same clock domain.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "wdte_params.svh"
module wdte_watchdog #(
	parameter int TICKS_PER_SECOND = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Slow time base tick
	input wire logic tick_in,
	// Event outputs
	output logic wake_output_n,
	output logic smi_output_n,
	output logic shared_watchdog_pin,
	output logic shared_watchdog_pin_oe,
	output logic [3:0] serirq_slot,
	output logic serirq_level
);

	// ==================================================
	// Registers
	logic [7:0] wake_global_enable_ff;
	logic [7:0] wake_status_two_ff;
	logic [7:0] wake_enable_two_ff;
	logic [7:0] timeout_units_ff;
	logic [7:0] watchdog_config_ff;
	logic [7:0] smi_status_three_ff;
	logic [7:0] smi_enable_three_ff;
	logic [7:0] countdown_value_ff;
	logic [7:0] pin_polarity_ff;
	logic [7:0] smi_pin_func_ff;
	logic [7:0] dog_pin_func_ff;
	logic [7:0] count_ff;
	logic status_ff;
	logic status_d_ff;
	logic [31:0] tick_cnt_ff;
	logic [5:0] sec_cnt_ff;
	logic [7:0] rdata_ff;
	wdte_pkg::wdte_state_t state_ff;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// ==================================================
	// Decode
	wire wr_val = reg_wr && hit(reg_addr, `WDTE_OFF_COUNTDOWN_VALUE);
	wire wr_ctrl = reg_wr && hit(reg_addr, `WDTE_OFF_WATCHDOG_CONTROL);
	wire reload = wr_val && (reg_wdata != `WDTE_COUNT_ZERO);
	wire disable_w = wr_val && (reg_wdata == `WDTE_COUNT_ZERO);
	wire force_w = wr_ctrl && reg_wdata[`WDTE_BIT_CTRL_FORCE];
	wire minutes = timeout_units_ff[`WDTE_BIT_UNITS_MINUTES];
	wire sec_tick = tick_in && (tick_cnt_ff == 32'(TICKS_PER_SECOND - 1));
	wire unit_tick = sec_tick && (!minutes || sec_cnt_ff == `WDTE_SECONDS_PER_MINUTE - 6'h01);
	wire running = (state_ff == wdte_pkg::WDTE_RUN);
	wire expire = running && unit_tick && (count_ff == 8'h01) && !reload;
	wire event_w = status_ff && !status_d_ff;
	wire dog_sel = (dog_pin_func_ff[`WDTE_DOG_FUNC_HI:`WDTE_DOG_FUNC_LO] == `WDTE_FUNC_DOG);
	wire smi_sel = (smi_pin_func_ff[`WDTE_SMI_FUNC_HI:`WDTE_SMI_FUNC_LO] == `WDTE_FUNC_SMI);
	wire [3:0] map_w = watchdog_config_ff[`WDTE_MAP_HI:`WDTE_MAP_LO];
	logic nxt_status;
	always_comb begin
		nxt_status = status_ff;
		if (wr_ctrl)
			nxt_status = reg_wdata[`WDTE_BIT_CTRL_STATUS];
		if (expire || force_w)
			nxt_status = 1'b1;
	end

	// ==================================================
	// Register writes
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_global_enable_ff <= `WDTE_REG_RESET;
			wake_enable_two_ff <= `WDTE_REG_RESET;
			timeout_units_ff <= `WDTE_REG_RESET;
			watchdog_config_ff <= `WDTE_REG_RESET;
			smi_enable_three_ff <= `WDTE_REG_RESET;
			countdown_value_ff <= `WDTE_REG_RESET;
			pin_polarity_ff <= `WDTE_REG_RESET;
			smi_pin_func_ff <= `WDTE_REG_RESET;
			dog_pin_func_ff <= `WDTE_REG_RESET;
		end else if (reg_wr) begin
			if (hit(reg_addr, `WDTE_OFF_WAKE_GLOBAL_ENABLE)) begin
				wake_global_enable_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_WAKE_ENABLE_TWO)) begin
				wake_enable_two_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_TIMEOUT_UNITS)) begin
				timeout_units_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_WATCHDOG_CONFIG)) begin
				watchdog_config_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_SMI_ENABLE_THREE)) begin
				smi_enable_three_ff <= reg_wdata;
			end
			if (wr_val) begin
				countdown_value_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_PIN_POLARITY)) begin
				pin_polarity_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_SMI_PIN_FUNC)) begin
				smi_pin_func_ff <= reg_wdata;
			end
			if (hit(reg_addr, `WDTE_OFF_DOG_PIN_FUNC)) begin
				dog_pin_func_ff <= reg_wdata;
			end
		end
	end

	// ==================================================
	// Status bits: event set wins over a write-one-to-clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_status_two_ff <= `WDTE_REG_RESET;
			smi_status_three_ff <= `WDTE_REG_RESET;
		end else begin
			if (reg_wr && hit(reg_addr, `WDTE_OFF_WAKE_STATUS_TWO))
				wake_status_two_ff <= wake_status_two_ff & ~reg_wdata;
			if (reg_wr && hit(reg_addr, `WDTE_OFF_SMI_STATUS_THREE))
				smi_status_three_ff <= smi_status_three_ff & ~reg_wdata;
			if (event_w) begin
				wake_status_two_ff[`WDTE_BIT_WAKE_DOG] <= 1'b1;
				smi_status_three_ff[`WDTE_BIT_SMI_DOG] <= 1'b1;
			end
		end
	end

	// ==================================================
	// Counter and prescaler
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= wdte_pkg::WDTE_IDLE;
			count_ff <= `WDTE_COUNT_ZERO;
			tick_cnt_ff <= 32'h0;
			sec_cnt_ff <= 6'h00;
			status_ff <= 1'b0;
			status_d_ff <= 1'b0;
		end else begin
			status_ff <= nxt_status;
			status_d_ff <= status_ff;
			if (reload) begin
				state_ff <= wdte_pkg::WDTE_RUN;
				count_ff <= reg_wdata;
				tick_cnt_ff <= 32'h0;
				sec_cnt_ff <= 6'h00;
			end else if (force_w || disable_w) begin
				state_ff <= wdte_pkg::WDTE_IDLE;
				count_ff <= `WDTE_COUNT_ZERO;
			end else if (running) begin
				if (tick_in)
					tick_cnt_ff <= sec_tick ? 32'h0 : tick_cnt_ff + 32'h1;
				if (sec_tick)
					sec_cnt_ff <= unit_tick ? 6'h00 : sec_cnt_ff + 6'h01;
				if (unit_tick) begin
					count_ff <= count_ff - 8'h01;
					if (expire)
						state_ff <= wdte_pkg::WDTE_IDLE;
				end
			end
		end
	end

	// ==================================================
	// Read path, data one cycle after strobe
	logic [7:0] rsel;
	always_comb begin
		rsel = 8'h00;
		unique case (reg_addr)
			`WDTE_OFF_WAKE_GLOBAL_ENABLE: rsel = wake_global_enable_ff;
			`WDTE_OFF_WAKE_STATUS_TWO: rsel = wake_status_two_ff;
			`WDTE_OFF_WAKE_ENABLE_TWO: rsel = wake_enable_two_ff;
			`WDTE_OFF_TIMEOUT_UNITS: rsel = timeout_units_ff;
			`WDTE_OFF_WATCHDOG_CONFIG: rsel = watchdog_config_ff;
			`WDTE_OFF_SMI_STATUS_THREE: rsel = smi_status_three_ff;
			`WDTE_OFF_SMI_ENABLE_THREE: rsel = smi_enable_three_ff;
			`WDTE_OFF_COUNTDOWN_VALUE: rsel = count_ff;
			`WDTE_OFF_WATCHDOG_CONTROL: rsel = {7'h00, status_ff};
			`WDTE_OFF_PIN_POLARITY: rsel = pin_polarity_ff;
			`WDTE_OFF_SMI_PIN_FUNC: rsel = smi_pin_func_ff;
			`WDTE_OFF_DOG_PIN_FUNC: rsel = dog_pin_func_ff;
			default: rsel = 8'h00;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst)
			rdata_ff <= 8'h00;
		else
			rdata_ff <= reg_rd ? rsel : 8'h00;
	end
	assign reg_rdata = rdata_ff;

	// ==================================================
	// Event outputs; wake and SMI are levels held by their sticky status bits
	logic wake_ff, smi_ff, pin_ff, serirq_ff;
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_ff <= 1'b0;
			smi_ff <= 1'b0;
			pin_ff <= 1'b0;
			serirq_ff <= 1'b0;
		end else begin
			wake_ff <= wake_status_two_ff[`WDTE_BIT_WAKE_DOG] && wake_global_enable_ff[`WDTE_BIT_WAKE_GLOBAL]
				&& wake_enable_two_ff[`WDTE_BIT_WAKE_DOG];
			smi_ff <= smi_status_three_ff[`WDTE_BIT_SMI_DOG] && smi_sel
				&& smi_enable_three_ff[`WDTE_BIT_SMI_DOG];
			pin_ff <= status_ff ^ pin_polarity_ff[`WDTE_BIT_PIN_POLARITY];
			serirq_ff <= status_ff && (map_w != `WDTE_MAP_NONE);
		end
	end
	assign wake_output_n = ~wake_ff;
	assign smi_output_n = ~smi_ff;
	assign shared_watchdog_pin = pin_ff;
	assign shared_watchdog_pin_oe = dog_sel;
	assign serirq_slot = map_w;
	assign serirq_level = serirq_ff;

	// ==================================================
	// Checks
	a_zero_stops: assert property (@(posedge clk) disable iff (rst)
		expire |=> !running && status_ff)
		else $error("counter did not stop with status at zero");
	a_reload_runs: assert property (@(posedge clk) disable iff (rst)
		reload |=> running && count_ff == $past(reg_wdata))
		else $error("reload not taken");
	a_zero_disables: assert property (@(posedge clk) disable iff (rst)
		disable_w |=> !running)
		else $error("zero write did not disable");
	a_force_sets: assert property (@(posedge clk) disable iff (rst)
		force_w && !reload |=> status_ff && count_ff == `WDTE_COUNT_ZERO)
		else $error("force did not time out");
	a_force_reads_zero: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == `WDTE_OFF_WATCHDOG_CONTROL |=> reg_rdata[`WDTE_BIT_CTRL_FORCE] == 1'b0)
		else $error("force bit read back set");
	a_status_write: assert property (@(posedge clk) disable iff (rst)
		wr_ctrl && !force_w && !expire |=> status_ff == $past(reg_wdata[`WDTE_BIT_CTRL_STATUS]))
		else $error("status write ignored");
	a_edge_event: assert property (@(posedge clk) disable iff (rst)
		$rose(status_ff) |=> wake_status_two_ff[`WDTE_BIT_WAKE_DOG] && smi_status_three_ff[`WDTE_BIT_SMI_DOG])
		else $error("edge did not set status");
	a_wake_gate: assert property (@(posedge clk) disable iff (rst)
		!wake_output_n |-> $past(wake_global_enable_ff[`WDTE_BIT_WAKE_GLOBAL] && wake_enable_two_ff[`WDTE_BIT_WAKE_DOG]))
		else $error("wake without enables");
	a_smi_gate: assert property (@(posedge clk) disable iff (rst)
		!smi_output_n |-> $past(smi_sel && smi_enable_three_ff[`WDTE_BIT_SMI_DOG]))
		else $error("smi without enables");
	a_pin_polarity: assert property (@(posedge clk) disable iff (rst)
		##1 shared_watchdog_pin == ($past(status_ff) ^ $past(pin_polarity_ff[`WDTE_BIT_PIN_POLARITY])))
		else $error("pin polarity wrong");
	a_serirq_map: assert property (@(posedge clk) disable iff (rst)
		serirq_level |-> $past(map_w) != `WDTE_MAP_NONE)
		else $error("serial irq with zero map");

	// ==================================================
	// Counter checks
	a_count_step: assert property (@(posedge clk) disable iff (rst)
		running && unit_tick && !reload && !force_w && !disable_w
		|=> count_ff == $past(count_ff) - 8'h01)
		else $error("counter missed a unit step");
	a_count_hold: assert property (@(posedge clk) disable iff (rst)
		(!running || !unit_tick) && !reload && !force_w && !disable_w
		|=> count_ff == $past(count_ff))
		else $error("counter moved without a unit step");
	a_idle_frozen: assert property (@(posedge clk) disable iff (rst)
		!running && !reload
		|=> !running)
		else $error("stopped counter restarted without reload");
	a_run_nonzero: assert property (@(posedge clk) disable iff (rst)
		running
		|-> count_ff != `WDTE_COUNT_ZERO)
		else $error("counter running at zero");
	a_force_stops: assert property (@(posedge clk) disable iff (rst)
		force_w
		|=> !running)
		else $error("force left counter running");

	// ==================================================
	// Prescaler checks
	a_prescale_restart: assert property (@(posedge clk) disable iff (rst)
		reload
		|=> sec_cnt_ff == 6'h00 && tick_cnt_ff == 32'h0)
		else $error("prescaler not restarted on reload");
	a_minute_range: assert property (@(posedge clk) disable iff (rst)
		1'b1
		|-> sec_cnt_ff < `WDTE_SECONDS_PER_MINUTE)
		else $error("seconds count out of range");
	a_tick_range: assert property (@(posedge clk) disable iff (rst)
		1'b1
		|-> tick_cnt_ff < 32'(TICKS_PER_SECOND))
		else $error("tick count out of range");

	// ==================================================
	// Status and event checks
	a_event_pulse: assert property (@(posedge clk) disable iff (rst)
		event_w
		|=> !event_w)
		else $error("event longer than one cycle");
	a_no_level_event: assert property (@(posedge clk) disable iff (rst)
		status_ff && $past(status_ff)
		|-> !event_w)
		else $error("event on steady status");
	a_status_sticky: assert property (@(posedge clk) disable iff (rst)
		status_ff && !wr_ctrl
		|=> status_ff)
		else $error("status dropped without a write");
	a_status_quiet: assert property (@(posedge clk) disable iff (rst)
		!status_ff && !wr_ctrl && !expire
		|=> !status_ff)
		else $error("status set without cause");
	a_read_status: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_addr == `WDTE_OFF_WATCHDOG_CONTROL
		|=> reg_rdata[`WDTE_BIT_CTRL_STATUS] == $past(status_ff))
		else $error("status read back wrong");

	// ==================================================
	// Output routing checks
	a_wake_sticky: assert property (@(posedge clk) disable iff (rst)
		wake_status_two_ff[`WDTE_BIT_WAKE_DOG] && !(reg_wr && reg_addr == `WDTE_OFF_WAKE_STATUS_TWO)
		|=> wake_status_two_ff[`WDTE_BIT_WAKE_DOG])
		else $error("wake status lost");
	a_smi_sticky: assert property (@(posedge clk) disable iff (rst)
		smi_status_three_ff[`WDTE_BIT_SMI_DOG] && !(reg_wr && reg_addr == `WDTE_OFF_SMI_STATUS_THREE)
		|=> smi_status_three_ff[`WDTE_BIT_SMI_DOG])
		else $error("smi status lost");
	a_wake_follows: assert property (@(posedge clk) disable iff (rst)
		wake_status_two_ff[`WDTE_BIT_WAKE_DOG] && wake_global_enable_ff[`WDTE_BIT_WAKE_GLOBAL]
		&& wake_enable_two_ff[`WDTE_BIT_WAKE_DOG] |=> !wake_output_n)
		else $error("enabled wake not driven");
	a_smi_follows: assert property (@(posedge clk) disable iff (rst)
		smi_status_three_ff[`WDTE_BIT_SMI_DOG] && smi_sel
		&& smi_enable_three_ff[`WDTE_BIT_SMI_DOG] |=> !smi_output_n)
		else $error("enabled smi not driven");
	a_pin_enable: assert property (@(posedge clk) disable iff (rst)
		shared_watchdog_pin_oe
		|-> dog_pin_func_ff[`WDTE_DOG_FUNC_HI:`WDTE_DOG_FUNC_LO] == `WDTE_FUNC_DOG)
		else $error("pin driven without watchdog function");
	a_serirq_follows: assert property (@(posedge clk) disable iff (rst)
		status_ff && map_w != `WDTE_MAP_NONE
		|=> serirq_level)
		else $error("mapped serial irq not raised");

endmodule // wdte_watchdog
